// File: verilog/vic_pkg.sv
// constants and types for the vectored interrupt controller
package vic_pkg;
    localparam int NUM_SRC = 18;
    localparam int IDX_W = 5;
    localparam logic [7:0] ADDR_INT_EN = 8'hA8;
    localparam logic [7:0] ADDR_SECOND_EN = 8'hE6;
    localparam logic [7:0] INT_EN_RESET = 8'h00;
    localparam logic [7:0] SECOND_EN_RESET = 8'h00;
    localparam logic [7:0] RDATA_UNMAPPED = 8'h00;
    // interrupt_enable bit positions, bit 7 down to bit 0
    localparam int EN_GATE = 7;
    localparam int EN_SPI = 6;
    localparam int EN_T2 = 5;
    localparam int EN_UART = 4;
    localparam int EN_T1 = 3;
    localparam int EN_PIN1 = 2;
    localparam int EN_T0 = 1;
    localparam int EN_PIN0 = 0;
    // fixed order numbers of the sources
    localparam int SRC_PIN0 = 0;
    localparam int SRC_T0 = 1;
    localparam int SRC_PIN1 = 2;
    localparam int SRC_T1 = 3;
    localparam int SRC_UART = 4;
    localparam int SRC_T2 = 5;
    localparam int SRC_SPI = 6;
    localparam int SRC_SMB = 7;
    localparam int SRC_ADC_WIN = 8;
    localparam int SRC_ADC_DONE = 9;
    localparam int SRC_PCA = 10;
    localparam int SRC_CMP0 = 11;
    localparam int SRC_CMP1 = 12;
    localparam int SRC_T3 = 13;
    localparam int SRC_LIN = 14;
    localparam int SRC_REG = 15;
    localparam int SRC_CAN = 16;
    localparam int SRC_PMAT = 17;
    localparam int SECOND_FIRST_SRC = 7;
    localparam int EXT_FIRST_SRC = 15;
    localparam logic [15:0] VEC_RESET = 16'h0000;
    localparam logic [15:0] VEC_BASE = 16'h0003;
    localparam int VEC_STEP_SHIFT = 3;
    localparam logic [17:0] AUTO_CLR_MASK = 18'h1000F;
    typedef enum logic [2:0] {
        ST_BOOT,
        ST_IDLE,
        ST_LOW,
        ST_HIGH,
        ST_HIGH_OVER_LOW
    } vic_state_type;
endpackage

// File: verilog/vic_arb_ifc.sv
// request and winner signals between controller and arbiter
`timescale 1ns/1ps
interface vic_arb_ifc #(parameter int N = 18, parameter int IW = 5);
    logic [N-1:0] req;
    logic [N-1:0] high;
    logic valid;
    logic is_high;
    logic [IW-1:0] index;
    modport arb (input req, input high, output valid, output is_high, output index);
    modport user (output req, output high, input valid, input is_high, input index);
endinterface

// File: verilog/vic_arbiter.sv
// fixed-order two-level arbiter
`timescale 1ns/1ps
module vic_arbiter #(
    parameter int N = 18,
    parameter int IW = 5
) (
    vic_arb_ifc.arb arb
);
    // high level first, lowest order number within a level
    always_comb begin
        arb.valid = 1'b0;
        arb.is_high = 1'b0;
        arb.index = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (arb.req[i] && !arb.high[i]) begin
                arb.valid = 1'b1;
                arb.index = IW'(i);
            end
        end
        for (int i = N - 1; i >= 0; i--) begin
            if (arb.req[i] && arb.high[i]) begin
                arb.valid = 1'b1;
                arb.is_high = 1'b1;
                arb.index = IW'(i);
            end
        end
    end
endmodule

// File: verilog/vic_top.sv
// vectored interrupt controller: enables, arbitration, nesting, vectors
`timescale 1ns/1ps
module vic_top #(
    parameter int PCA_MODULES = 6
) (
    input wire logic i_clk_sys,
    input wire logic i_arst_n,
    input wire logic [7:0] i_sfr_addr,
    input wire logic i_sfr_wr,
    input wire logic i_sfr_rd,
    input wire logic [7:0] i_sfr_wdata,
    input wire logic i_sfr_bit_wr,
    input wire logic [7:0] i_sfr_bit_addr,
    input wire logic i_sfr_bit_val,
    output logic [7:0] o_sfr_rdata,
    input wire logic [17:0] i_prio_high,
    input wire logic [2:0] i_enable_ext,
    input wire logic i_pin_irq_zero,
    input wire logic i_pin_irq_one,
    input wire logic i_timer0_overflow_flag,
    input wire logic i_timer1_overflow_flag,
    input wire logic i_uart_rx_done,
    input wire logic i_uart_tx_done,
    input wire logic i_timer2_high_overflow_flag,
    input wire logic i_timer2_low_overflow_flag,
    input wire logic i_spi_transfer_done,
    input wire logic i_spi_write_collision,
    input wire logic i_spi_mode_fault,
    input wire logic i_spi_rx_overrun,
    input wire logic i_smbus_flag,
    input wire logic i_adc_window_flag,
    input wire logic i_adc_done_flag,
    input wire logic i_pca_counter_overflow,
    input wire logic [PCA_MODULES-1:0] i_pca_module_match,
    input wire logic i_pca_pwm_cycle_overflow,
    input wire logic i_comp0_falling_flag,
    input wire logic i_comp0_rising_flag,
    input wire logic i_comp1_falling_flag,
    input wire logic i_comp1_rising_flag,
    input wire logic i_timer3_high_overflow_flag,
    input wire logic i_timer3_low_overflow_flag,
    input wire logic i_lin_flag,
    input wire logic i_regulator_flag,
    input wire logic i_can_pending_flag,
    input wire logic i_port_match,
    output logic o_irq_req,
    output logic [15:0] o_irq_vector,
    output logic [4:0] o_irq_order,
    output logic o_irq_high,
    input wire logic i_irq_accept,
    input wire logic i_irq_return,
    output logic [17:0] o_clear_pulse,
    output logic [17:0] o_pending
);
    localparam int N = vic_pkg::NUM_SRC;
    localparam int IW = vic_pkg::IDX_W;

    logic [7:0] int_en_reg, int_en_next, second_en_reg, second_en_next, rdata_reg, rdata_next;
    vic_pkg::vic_state_type state_reg, state_next;
    logic req_reg, req_next, level_reg, level_next, accept_take;
    logic [15:0] vec_reg, vec_next;
    logic [IW-1:0] order_reg, order_next;
    logic [N-1:0] clr_reg, clr_next, pend_reg, pend_raw, enable_all, masked_req;

    vic_arb_ifc #(.N(N), .IW(IW)) arb_bus ();
    vic_arbiter #(.N(N), .IW(IW)) u_arbiter (.arb(arb_bus));

    // raw flags per source, combined where a vector is shared
    always_comb begin
        pend_raw = '0;
        pend_raw[vic_pkg::SRC_PIN0] = i_pin_irq_zero;
        pend_raw[vic_pkg::SRC_T0] = i_timer0_overflow_flag;
        pend_raw[vic_pkg::SRC_PIN1] = i_pin_irq_one;
        pend_raw[vic_pkg::SRC_T1] = i_timer1_overflow_flag;
        pend_raw[vic_pkg::SRC_UART] = i_uart_rx_done | i_uart_tx_done;
        pend_raw[vic_pkg::SRC_T2] = i_timer2_high_overflow_flag | i_timer2_low_overflow_flag;
        pend_raw[vic_pkg::SRC_SPI] = i_spi_transfer_done | i_spi_write_collision
            | i_spi_mode_fault | i_spi_rx_overrun;
        pend_raw[vic_pkg::SRC_SMB] = i_smbus_flag;
        pend_raw[vic_pkg::SRC_ADC_WIN] = i_adc_window_flag;
        pend_raw[vic_pkg::SRC_ADC_DONE] = i_adc_done_flag;
        pend_raw[vic_pkg::SRC_PCA] = i_pca_counter_overflow | (|i_pca_module_match)
            | i_pca_pwm_cycle_overflow;
        pend_raw[vic_pkg::SRC_CMP0] = i_comp0_falling_flag | i_comp0_rising_flag;
        pend_raw[vic_pkg::SRC_CMP1] = i_comp1_falling_flag | i_comp1_rising_flag;
        pend_raw[vic_pkg::SRC_T3] = i_timer3_high_overflow_flag | i_timer3_low_overflow_flag;
        pend_raw[vic_pkg::SRC_LIN] = i_lin_flag;
        pend_raw[vic_pkg::SRC_REG] = i_regulator_flag;
        pend_raw[vic_pkg::SRC_CAN] = i_can_pending_flag;
        pend_raw[vic_pkg::SRC_PMAT] = i_port_match;
    end

    // interrupt_enable bits 6..0 line up with orders 6..0
    assign enable_all = {i_enable_ext, second_en_reg,
        int_en_reg[vic_pkg::EN_SPI:vic_pkg::EN_PIN0]};
    assign masked_req = pend_raw & enable_all & {N{int_en_reg[vic_pkg::EN_GATE]}};
    assign accept_take = i_irq_accept && req_reg;

    // register file: byte and bit writes, registered reads
    always_comb begin
        int_en_next = int_en_reg;
        second_en_next = second_en_reg;
        rdata_next = rdata_reg;
        if (i_sfr_wr && i_sfr_addr == vic_pkg::ADDR_INT_EN) begin
            int_en_next = i_sfr_wdata;
        end
        if (i_sfr_bit_wr && i_sfr_bit_addr[7:3] == vic_pkg::ADDR_INT_EN[7:3]) begin
            int_en_next[i_sfr_bit_addr[2:0]] = i_sfr_bit_val;
        end
        if (i_sfr_wr && i_sfr_addr == vic_pkg::ADDR_SECOND_EN) begin
            second_en_next = i_sfr_wdata;
        end
        if (i_sfr_rd) begin
            case (i_sfr_addr)
                vic_pkg::ADDR_INT_EN: rdata_next = int_en_reg;
                vic_pkg::ADDR_SECOND_EN: rdata_next = second_en_reg;
                default: rdata_next = vic_pkg::RDATA_UNMAPPED;
            endcase
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            int_en_reg <= vic_pkg::INT_EN_RESET;
            second_en_reg <= vic_pkg::SECOND_EN_RESET;
            rdata_reg <= vic_pkg::RDATA_UNMAPPED;
        end else begin
            int_en_reg <= int_en_next;
            second_en_reg <= second_en_next;
            rdata_reg <= rdata_next;
        end
    end

    // nesting state and the registered request to the core
    always_comb begin
        state_next = state_reg;
        clr_next = '0;
        case (state_reg)
            vic_pkg::ST_BOOT: begin
                if (i_irq_accept) begin
                    state_next = vic_pkg::ST_IDLE;
                end
            end
            vic_pkg::ST_IDLE: begin
                if (accept_take) begin
                    state_next = level_reg ? vic_pkg::ST_HIGH : vic_pkg::ST_LOW;
                end
            end
            vic_pkg::ST_LOW: begin
                if (accept_take) begin
                    state_next = vic_pkg::ST_HIGH_OVER_LOW;
                end else if (i_irq_return) begin
                    state_next = vic_pkg::ST_IDLE;
                end
            end
            vic_pkg::ST_HIGH: begin
                if (i_irq_return) begin
                    state_next = vic_pkg::ST_IDLE;
                end
            end
            vic_pkg::ST_HIGH_OVER_LOW: begin
                if (i_irq_return) begin
                    state_next = vic_pkg::ST_LOW;
                end
            end
            default: state_next = vic_pkg::ST_IDLE;
        endcase
        if (accept_take && state_reg != vic_pkg::ST_BOOT
            && vic_pkg::AUTO_CLR_MASK[order_reg]) begin
            clr_next[order_reg] = 1'b1;
        end
    end

    // eligibility uses the next state so an accepted request drops at once
    always_comb begin
        arb_bus.high = i_prio_high;
        case (state_next)
            vic_pkg::ST_IDLE: arb_bus.req = masked_req;
            vic_pkg::ST_LOW: arb_bus.req = masked_req & i_prio_high;
            default: arb_bus.req = '0;
        endcase
        if (state_next == vic_pkg::ST_BOOT) begin
            req_next = 1'b1;
            vec_next = vic_pkg::VEC_RESET;
            order_next = '0;
            level_next = 1'b1;
        end else begin
            req_next = arb_bus.valid;
            vec_next = vic_pkg::VEC_BASE + (16'(arb_bus.index) << vic_pkg::VEC_STEP_SHIFT);
            order_next = arb_bus.index;
            level_next = arb_bus.is_high;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state_reg <= vic_pkg::ST_BOOT;
            req_reg <= 1'b1;
            vec_reg <= vic_pkg::VEC_RESET;
            order_reg <= '0;
            level_reg <= 1'b1;
            clr_reg <= '0;
            pend_reg <= '0;
        end else begin
            state_reg <= state_next;
            req_reg <= req_next;
            vec_reg <= vec_next;
            order_reg <= order_next;
            level_reg <= level_next;
            clr_reg <= clr_next;
            pend_reg <= pend_raw;
        end
    end

    assign o_irq_req = req_reg;
    assign o_irq_vector = vec_reg;
    assign o_irq_order = order_reg;
    assign o_irq_high = level_reg;
    assign o_clear_pulse = clr_reg;
    assign o_pending = pend_reg;
    assign o_sfr_rdata = rdata_reg;

    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_arst_n);

    property p_vector_map;
        o_irq_req && state_reg != vic_pkg::ST_BOOT |-> o_irq_vector == 16'h0003 + {8'h00, o_irq_order, 3'b000};
    endproperty
    a_vector_map: assert property (p_vector_map) else $error("vector does not match order");
    property p_auto_clear;
        i_irq_accept && o_irq_req && state_reg != vic_pkg::ST_BOOT
            ##0 (o_irq_order <= 5'd3 || o_irq_order == 5'd16)
            |=> o_clear_pulse == (18'h00001 << $past(o_irq_order));
    endproperty
    a_auto_clear: assert property (p_auto_clear) else $error("auto-clear pulse missing");
    // port match has no hardware clear either, so bit 17 stays quiet
    property p_no_clear_others;
        (o_clear_pulse & 18'h2FFF0) == 18'h00000 && $countones(o_clear_pulse) <= 1;
    endproperty
    a_no_clear_others: assert property (p_no_clear_others) else $error("clear pulse on a software-cleared source");
    property p_gate_blocks;
        !int_en_reg[7] && state_reg != vic_pkg::ST_BOOT && !i_sfr_wr && !i_sfr_bit_wr |=> !o_irq_req;
    endproperty
    a_gate_blocks: assert property (p_gate_blocks) else $error("request while gate is off");
    // other enabled sources of high level could outrank the uart
    property p_uart_req;
        state_reg == vic_pkg::ST_IDLE && !i_irq_accept && int_en_reg == 8'h90 && i_uart_tx_done
            && pend_raw[3:0] == 4'h0 && second_en_reg == 8'h00 && i_enable_ext == 3'h0
            |=> o_irq_req && o_irq_order == 5'd4;
    endproperty
    a_uart_req: assert property (p_uart_req) else $error("uart vector not requested");
    property p_mask_t2;
        o_irq_req && o_irq_order == 5'd5 |-> $past(int_en_reg[5]) && $past(i_timer2_high_overflow_flag
            || i_timer2_low_overflow_flag);
    endproperty
    a_mask_t2: assert property (p_mask_t2) else $error("timer 2 request without mask or flag");
    property p_mask_spi;
        o_irq_req && o_irq_order == 5'd6 |-> $past(int_en_reg[6]);
    endproperty
    a_mask_spi: assert property (p_mask_spi) else $error("serial request while masked");
    // a return may legally raise the next request, so look at this cycle and the next only
    property p_no_preempt_high;
        (state_reg == vic_pkg::ST_HIGH || state_reg == vic_pkg::ST_HIGH_OVER_LOW) && !i_irq_return
            |-> (!o_irq_req) [*2];
    endproperty
    a_no_preempt_high: assert property (p_no_preempt_high) else $error("high handler preempted");
    property p_low_only_high;
        state_reg == vic_pkg::ST_LOW && o_irq_req |-> o_irq_high;
    endproperty
    a_low_only_high: assert property (p_low_only_high) else $error("equal-level request during low handler");
    property p_order_lowest;
        o_irq_req && state_reg == vic_pkg::ST_IDLE && !o_irq_high |->
            ($past(arb_bus.req) & ((18'h00001 << o_irq_order) - 18'h00001)) == 18'h00000;
    endproperty
    a_order_lowest: assert property (p_order_lowest) else $error("lower order number skipped");
    property p_boot_entry;
        state_reg == vic_pkg::ST_BOOT |-> o_irq_req && o_irq_vector == 16'h0000;
    endproperty
    a_boot_entry: assert property (p_boot_entry) else $error("reset entry not at zero");
endmodule

// File: sim/vic_core_model.sv
// core-side model: takes vectors and returns from handlers
`timescale 1ns/1ps
module vic_core_model (
    input wire logic i_clk_sys,
    input wire logic i_arst_n,
    input wire logic i_take,
    input wire logic i_finish,
    input wire logic [1:0] i_lat,
    input wire logic i_irq_req,
    input wire logic [15:0] i_irq_vector,
    output logic o_irq_accept,
    output logic o_irq_return,
    output logic [15:0] o_taken_vec
);
    logic armed_reg;
    logic [1:0] wait_reg;
    // a slow core lets the request stand a few cycles before taking it
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            armed_reg <= 1'b0;
            wait_reg <= 2'h0;
            o_irq_accept <= 1'b0;
            o_irq_return <= 1'b0;
            o_taken_vec <= 16'hFFFF;
        end else begin
            o_irq_accept <= 1'b0;
            o_irq_return <= i_finish;
            if (o_irq_accept && i_irq_req) begin
                o_taken_vec <= i_irq_vector;
            end
            if (i_take) begin
                armed_reg <= 1'b1;
                wait_reg <= 2'h0;
            end else if (armed_reg && i_irq_req) begin
                if (wait_reg == i_lat) begin
                    o_irq_accept <= 1'b1;
                    armed_reg <= 1'b0;
                end else begin
                    wait_reg <= wait_reg + 2'h1;
                end
            end
        end
    end
endmodule

// File: sim/vic_top_tb.sv
// self-checking bench for the vectored interrupt controller
`timescale 1ns/1ps
module vic_top_tb;
    logic clk = 1'b0, arst_n = 1'b0, take = 1'b0, fin = 1'b0, acc, ret, req, high;
    logic sfr_wr = 1'b0, sfr_rd = 1'b0, bit_wr = 1'b0, bit_val = 1'b0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, bit_addr = 8'h00, rdata;
    logic [17:0] prio = 18'h00000, cap = 18'h00000, cap0 = 18'h00000, clr, pend;
    logic [2:0] ext = 3'h0;
    logic [1:0] lat = 2'h0;
    logic [32:0] fl = 33'h0;
    logic [15:0] vec, taken;
    logic [4:0] order;
    int err_count = 0, total_checks = 0, cycles = 0;
    // first flag bit and flag count of each source in fl
    int first [18] = '{0, 1, 2, 3, 4, 6, 8, 12, 13, 14, 15, 23, 25, 27, 29, 30, 31, 32};
    int cnt [18] = '{1, 1, 1, 1, 2, 2, 4, 1, 1, 1, 8, 2, 2, 2, 1, 1, 1, 1};

    vic_top #(.PCA_MODULES(6)) dut_u (
        .i_clk_sys(clk), .i_arst_n(arst_n), .i_sfr_addr(addr), .i_sfr_wr(sfr_wr), .i_sfr_rd(sfr_rd),
        .i_sfr_wdata(wdata), .i_sfr_bit_wr(bit_wr), .i_sfr_bit_addr(bit_addr), .i_sfr_bit_val(bit_val),
        .o_sfr_rdata(rdata), .i_prio_high(prio), .i_enable_ext(ext), .i_pin_irq_zero(fl[0]),
        .i_timer0_overflow_flag(fl[1]), .i_pin_irq_one(fl[2]), .i_timer1_overflow_flag(fl[3]),
        .i_uart_rx_done(fl[4]), .i_uart_tx_done(fl[5]), .i_timer2_high_overflow_flag(fl[6]),
        .i_timer2_low_overflow_flag(fl[7]), .i_spi_transfer_done(fl[8]), .i_spi_write_collision(fl[9]),
        .i_spi_mode_fault(fl[10]), .i_spi_rx_overrun(fl[11]), .i_smbus_flag(fl[12]),
        .i_adc_window_flag(fl[13]), .i_adc_done_flag(fl[14]), .i_pca_counter_overflow(fl[15]),
        .i_pca_module_match(fl[21:16]), .i_pca_pwm_cycle_overflow(fl[22]), .i_comp0_falling_flag(fl[23]),
        .i_comp0_rising_flag(fl[24]), .i_comp1_falling_flag(fl[25]), .i_comp1_rising_flag(fl[26]),
        .i_timer3_high_overflow_flag(fl[27]), .i_timer3_low_overflow_flag(fl[28]), .i_lin_flag(fl[29]),
        .i_regulator_flag(fl[30]), .i_can_pending_flag(fl[31]), .i_port_match(fl[32]), .o_irq_req(req),
        .o_irq_vector(vec), .o_irq_order(order), .o_irq_high(high), .i_irq_accept(acc),
        .i_irq_return(ret), .o_clear_pulse(clr), .o_pending(pend));
    vic_core_model core_u (.i_clk_sys(clk), .i_arst_n(arst_n), .i_take(take), .i_finish(fin), .i_lat(lat),
        .i_irq_req(req), .i_irq_vector(vec), .o_irq_accept(acc), .o_irq_return(ret), .o_taken_vec(taken));

    initial begin
        forever #5 clk = ~clk;
    end
    // sticky copy, clear pulses last only one cycle
    always @(posedge clk) cap <= cap | clr;
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            err_count++;
            $display("MISMATCH t=%0t timeout", $time);
            wrap_up();
        end
    end

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input logic [17:0] got, input logic [17:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        sfr_wr <= 1'b1;
        @(posedge clk);
        sfr_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        sfr_rd <= 1'b1;
        @(posedge clk);
        sfr_rd <= 1'b0;
        #1;
        chk(18'(rdata), 18'(e), "read");
    endtask
    task automatic bw(input logic [2:0] n, input logic v);
        @(posedge clk);
        bit_addr <= 8'hA8 + {5'h00, n};
        bit_val <= v;
        bit_wr <= 1'b1;
        @(posedge clk);
        bit_wr <= 1'b0;
    endtask
    task automatic en(input logic g, input logic [17:0] m);
        wr(8'hA8, {g, m[6:0]});
        wr(8'hE6, m[14:7]);
        ext <= m[17:15];
    endtask
    task automatic take_one();
        int n;
        @(posedge clk);
        take <= 1'b1;
        @(posedge clk);
        take <= 1'b0;
        n = 0;
        while (acc !== 1'b1 && n < 40) begin
            @(posedge clk);
            n++;
        end
        if (n >= 40) begin
            err_count++;
            $display("MISMATCH t=%0t no accept", $time);
        end
        tick(1);
    endtask
    task automatic finish_one();
        @(posedge clk);
        fin <= 1'b1;
        @(posedge clk);
        fin <= 1'b0;
        tick(3);
    endtask

    initial begin
        tick(2);
        chk(18'(req), 18'h1, "reset req");
        chk(18'(vec), 18'h0, "reset vector");
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        rd(8'hA8, 8'h00);
        rd(8'hE6, 8'h00);
        take_one();
        chk(18'(taken), 18'h0, "reset entry");
        tick(2);
        chk(18'(req), 18'h0, "after entry");
        chk(cap, 18'h0, "entry clears");
        $display("test reset done");
        wr(8'hA8, 8'h5A);
        rd(8'hA8, 8'h5A);
        bw(3'h7, 1'b1);
        bw(3'h1, 1'b0);
        rd(8'hA8, 8'hD8);
        wr(8'hE6, 8'hA5);
        wr(8'h3C, 8'hFF);
        rd(8'hE6, 8'hA5);
        rd(8'hA8, 8'hD8);
        rd(8'h3C, 8'h00);
        $display("test registers done");
        for (int o = 0; o < 18; o++) begin
            for (int v = 0; v < cnt[o]; v++) begin
                en(1'b1, 18'h1 << o);
                @(posedge clk);
                fl <= 33'h1 << (first[o] + v);
                lat <= 2'(o);
                tick(3);
                chk(18'(req), 18'h1, "req");
                chk(18'(order), 18'(o), "order");
                chk(18'(pend[o]), 18'h1, "pending");
                cap0 = cap;
                take_one();
                chk(18'(taken), 18'(16'h0003 + 16'(o * 8)), "vector");
                tick(3);
                chk(cap, cap0 | 18'((o < 4 || o == 16) ? 1 << o : 0), "auto clear");
                @(posedge clk);
                fl <= 33'h0;
                tick(3);
                finish_one();
            end
            en(1'b1, ~(18'h1 << o));
            @(posedge clk);
            fl <= 33'h1 << first[o];
            tick(3);
            chk(18'(req), 18'h0, "own mask");
            chk(18'(pend[o]), 18'h1, "masked pending");
            en(1'b0, 18'h3FFFF);
            tick(3);
            chk(18'(req), 18'h0, "gate");
            @(posedge clk);
            fl <= 33'h0;
        end
        $display("test sources done");
        en(1'b1, 18'h00024);
        @(posedge clk);
        fl <= 33'h44;
        tick(3);
        chk(18'(order), 18'h2, "equal level");
        @(posedge clk);
        prio <= 18'h00020;
        tick(3);
        chk(18'({order, high}), 18'h0B, "high wins");
        @(posedge clk);
        prio <= 18'h0;
        tick(1);
        take_one();
        @(posedge clk);
        fl <= 33'h40;
        tick(3);
        chk(18'(req), 18'h0, "low on low");
        @(posedge clk);
        prio <= 18'h00021;
        tick(3);
        chk(18'({req, order}), 18'h25, "preempt");
        take_one();
        en(1'b1, 18'h00025);
        fl <= 33'h41;
        tick(3);
        chk(18'(req), 18'h0, "high held");
        finish_one();
        chk(18'({req, order}), 18'h20, "back to low");
        @(posedge clk);
        fl <= 33'h0;
        tick(3);
        finish_one();
        chk(18'(req), 18'h0, "idle");
        $display("test priority done");
        wrap_up();
    end
endmodule
